// [lds_pkg.sv]
// Purpose: shared constants and carrier types for the led driver shift port
// Assumes: one 769-bit common shift register, 48 channels per flag group
// Notes:   grayscale writes leave the block as 16 words of 48 bits
package lds_pkg;

   localparam int SHIFT_LEN   = 769;            // common shift register length
   localparam int SHIFT_MSB   = SHIFT_LEN - 1;  // select bit, drives serial_out
   localparam int CHANNELS    = 48;             // flags per detection group
   localparam int GS_WORD_W   = 48;             // grayscale word width
   localparam int GS_WORDS    = 16;             // words per grayscale write
   localparam int DATA_W      = GS_WORD_W * GS_WORDS;  // 768 payload bits
   localparam int SID_W       = 2 * CHANNELS;          // status bits
   localparam int SID_LSB     = SHIFT_LEN - SID_W;     // status lands at top
   localparam int FIFO_DEPTH  = 16;
   localparam logic [4:0] GS_WORD_CNT = 5'h10;  // words left after a write
   localparam logic [SHIFT_LEN-1:0] SHIFT_RST = '0;
   localparam logic [DATA_W-1:0]    DATA_RST  = '0;

   // detection results as presented by the output stage
   typedef struct packed {
      logic [CHANNELS-1:0] openLed;
      logic [CHANNELS-1:0] shortLed;
   } lds_flags_t;

endpackage

// [lds_shift_port.sv]
// Purpose: serial shift port of a 48-channel led sink driver with status read-back
// Assumes: shiftClk stands still around every latch_strobe pulse (host keeps that)
// Notes:   shift register lives on shiftClk; latch decode and output fifo on clk
//
// Behaviour
// R1: serial input enters shift register bit zero
// R2: each shift edge moves bits toward top
// R3: shift register is exactly 769 bits
// R4: serial output shows top bit, advancing
// R5: after grayscale latch falls, load detection status
// R6: latch rise: top bit selects grayscale/control
// R7: host shifts full frame, then pulses latch
`timescale 1ns/100ps

module lds_fifo
   import lds_pkg::*;
#(
   parameter int WIDTH = GS_WORD_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady,
   output logic                  outValid
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [AW:0]      count_reg, count_next;
   logic [WIDTH-1:0] outData_reg, outData_next;
   logic             outValid_reg, outValid_next;
   logic             doPush, doPop;

   // full at DEPTH entries; the output stage holds one word more
   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign outData  = outData_reg;
   assign outValid = outValid_reg;

   // output stage refills whenever empty or being taken
   always_comb
   begin
      doPush        = inValid && inReady;
      doPop         = (count_reg != '0) && (!outValid_reg || outReady);
      wrPtr_next    = doPush ? wrPtr_reg + AW'(1) : wrPtr_reg;
      rdPtr_next    = doPop ? rdPtr_reg + AW'(1) : rdPtr_reg;
      count_next    = count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
      outData_next  = doPop ? mem[rdPtr_reg] : outData_reg;
      outValid_next = doPop || (outValid_reg && !outReady);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_reg    <= '0;
         rdPtr_reg    <= '0;
         count_reg    <= '0;
         outData_reg  <= '0;
         outValid_reg <= 1'b0;
      end
      else
      begin
         wrPtr_reg    <= wrPtr_next;
         rdPtr_reg    <= rdPtr_next;
         count_reg    <= count_next;
         outData_reg  <= outData_next;
         outValid_reg <= outValid_next;
      end
   end

   // storage has no reset, only written on push
   always_ff @(posedge clk)
   begin
      if (doPush)
         mem[wrPtr_reg] <= inData;
   end
endmodule

module lds_shift_port
   import lds_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              shiftClk,
   input  wire logic              serialIn,
   input  wire logic              latchStrobe,
   output logic                   serialOut,
   input  wire lds_flags_t        ledFlags,
   output logic [GS_WORD_W-1:0]   grayscaleWord,
   output logic                   grayscaleValid,
   input  wire logic              grayscaleReady,
   output logic [DATA_W-1:0]      controlLatch,
   output logic                   controlStrobe
);
   // link domain (shiftClk)
   logic [SHIFT_LEN-1:0] shiftReg_reg, shiftReg_next;
   logic                 sidSync1_reg, sidSync2_reg, sidSeen_reg;
   logic                 sidSeen_next;
   // system domain (clk)
   logic                 latSync1_reg, latSync2_reg, latPrev_reg;
   logic                 latRise, latFall;
   logic [DATA_W-1:0]    ctrl_reg, ctrl_next;
   logic                 ctrlStb_reg, ctrlStb_next;
   logic [DATA_W-1:0]    gsBuf_reg, gsBuf_next;
   logic [4:0]           gsLeft_reg, gsLeft_next;
   logic                 lastGs_reg, lastGs_next;
   lds_flags_t           sid_reg, sid_next;
   logic                 sidTgl_reg, sidTgl_next;
   logic                 fifoInReady, fifoPush;

   assign serialOut     = shiftReg_reg[SHIFT_MSB];  // R4
   assign controlLatch  = ctrl_reg;
   assign controlStrobe = ctrlStb_reg;

   // shift register: status load takes the top, low part still shifts
   always_comb
   begin
      shiftReg_next = {shiftReg_reg[SHIFT_LEN-2:0], serialIn};  // R1 R2 R3
      sidSeen_next  = sidSync2_reg;
      if (sidSync2_reg != sidSeen_reg)
         shiftReg_next = {sid_reg, shiftReg_reg[SID_LSB-2:0], serialIn};  // R5
   end

   // toggle crossing for the status load; sid_reg is stable by then
   always_ff @(posedge shiftClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shiftReg_reg <= SHIFT_RST;
         sidSync1_reg <= 1'b0;
         sidSync2_reg <= 1'b0;
         sidSeen_reg  <= 1'b0;
      end
      else
      begin
         shiftReg_reg <= shiftReg_next;
         sidSync1_reg <= sidTgl_reg;
         sidSync2_reg <= sidSync1_reg;
         sidSeen_reg  <= sidSeen_next;
      end
   end

   // latch strobe comes off a pin, two flops before use
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latSync1_reg <= 1'b0;
         latSync2_reg <= 1'b0;
         latPrev_reg  <= 1'b0;
      end
      else
      begin
         latSync1_reg <= latchStrobe;
         latSync2_reg <= latSync1_reg;
         latPrev_reg  <= latSync2_reg;
      end
   end

   assign latRise  = latSync2_reg && !latPrev_reg;
   assign latFall  = !latSync2_reg && latPrev_reg;
   assign fifoPush = (gsLeft_reg != 5'h00);

   // latch decode; shift register read here is quiet since shiftClk is idle
   always_comb
   begin
      ctrl_next    = ctrl_reg;
      ctrlStb_next = 1'b0;
      gsBuf_next   = gsBuf_reg;
      gsLeft_next  = gsLeft_reg;
      lastGs_next  = lastGs_reg;
      sid_next     = sid_reg;
      sidTgl_next  = sidTgl_reg;
      if (fifoPush && fifoInReady)
      begin
         gsBuf_next  = gsBuf_reg >> GS_WORD_W;
         gsLeft_next = gsLeft_reg - 5'h01;
      end
      if (latRise)  // R7
      begin
         if (shiftReg_reg[SHIFT_MSB])  // R6
         begin
            ctrl_next    = shiftReg_reg[DATA_W-1:0];
            ctrlStb_next = 1'b1;
            lastGs_next  = 1'b0;
         end
         else
         begin
            // a new write restarts any drain still in progress
            gsBuf_next  = shiftReg_reg[DATA_W-1:0];  // R6
            gsLeft_next = GS_WORD_CNT;
            lastGs_next = 1'b1;
         end
      end
      if (latFall && lastGs_reg)
      begin
         sid_next    = ledFlags;  // R5
         sidTgl_next = !sidTgl_reg;
         lastGs_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg    <= DATA_RST;
         ctrlStb_reg <= 1'b0;
         gsBuf_reg   <= DATA_RST;
         gsLeft_reg  <= 5'h00;
         lastGs_reg  <= 1'b0;
         sid_reg     <= '0;
         sidTgl_reg  <= 1'b0;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         ctrlStb_reg <= ctrlStb_next;
         gsBuf_reg   <= gsBuf_next;
         gsLeft_reg  <= gsLeft_next;
         lastGs_reg  <= lastGs_next;
         sid_reg     <= sid_next;
         sidTgl_reg  <= sidTgl_next;
      end
   end

   // grayscale words drain low word first; a slow consumer stalls the drain
   lds_fifo #(
      .WIDTH (GS_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inData   (gsBuf_reg[GS_WORD_W-1:0]),
      .inValid  (fifoPush),
      .inReady  (fifoInReady),
      .outData  (grayscaleWord),
      .outReady (grayscaleReady),
      .outValid (grayscaleValid)
   );
endmodule

// [lds_shift_port_props.sv]
// Purpose: latch and handshake checks at the shift port
// Assumes: shiftClk idle while latchStrobe moves
// Notes:   serial path is judged by the bench
`timescale 1ns/100ps
module lds_shift_port_props
   import lds_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 shiftClk,
   input wire logic                 serialIn,
   input wire logic                 latchStrobe,
   input wire logic                 serialOut,
   input wire lds_flags_t           ledFlags,
   input wire logic [GS_WORD_W-1:0] grayscaleWord,
   input wire logic                 grayscaleValid,
   input wire logic                 grayscaleReady,
   input wire logic [DATA_W-1:0]    controlLatch,
   input wire logic                 controlStrobe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // top bit is quasi-static at the latch, so it names the target
   sequence s_latch(sel);
      $rose(latchStrobe) && serialOut == sel;
   endsequence
   a_ctrl_select: assert property (s_latch(1'h1) |-> ##[2:8] controlStrobe) else $error("no control strobe");
   a_gs_select: assert property (s_latch(1'h0) |-> ##[3:9] grayscaleValid) else $error("no grayscale word");
   a_gs_no_ctrl: assert property (s_latch(1'h0) |-> !controlStrobe [*8]) else $error("stray strobe");
   a_strobe_single: assert property (controlStrobe |=> !controlStrobe) else $error("long strobe");
   // latch and strobe are written on the same edge, so they are seen together
   a_ctrl_cause: assert property ($changed(controlLatch) |-> controlStrobe) else $error("silent update");
   a_word_hold: assert property (grayscaleValid && !grayscaleReady |=> grayscaleValid && $stable(grayscaleWord))
      else $error("word dropped");
endmodule

// [lds_host_model.sv]
// Purpose: host side of the serial link
// Assumes: link clock runs only inside frames, apart from the bare edges given while reset holds
// Notes:   serialOut sampled just before each shift edge
`timescale 1ns/100ps
module lds_host_model
   import lds_pkg::*;
(
   output logic      shiftClk,
   output logic      serialIn,
   output logic      latchStrobe,
   input  wire logic serialOut
);
   initial
   begin
      shiftClk = 1'h0;
      serialIn = 1'h0;
      latchStrobe = 1'h0;
   end
   // bare edges, used while reset holds
   task automatic tick(input int n);
      repeat (n)
      begin
         #16 shiftClk = 1'h1;
         #16 shiftClk = 1'h0;
      end
   endtask
   // select bit goes first; data changes at the fall for hold margin
   task automatic shift_frame(input logic [SHIFT_MSB:0] d, output logic [SHIFT_MSB:0] seen);
      for (int k = 0; k < SHIFT_LEN; k++)
      begin
         serialIn = d[SHIFT_MSB-k];
         #8 seen[SHIFT_MSB-k] = serialOut;
         #8 shiftClk = 1'h1;
         #16 shiftClk = 1'h0;
      end
      serialIn = ~serialIn; // idle line not the last bit
   endtask
   task automatic pulse_latch();
      #150 latchStrobe = 1'h1;
      #200 latchStrobe = 1'h0;
      #200;
   endtask
endmodule

// [lds_shift_port_tb.sv]
// Purpose: self-checking bench for lds_shift_port
// Assumes: host model paces link and latch
// Notes:   fifo drained with ready toggling
`timescale 1ns/100ps
module lds_shift_port_tb
   import lds_pkg::*;
;
   logic                 clk, rst_n, shiftClk, serialIn, latchStrobe, serialOut;
   logic                 grayscaleValid, grayscaleReady, controlStrobe;
   lds_flags_t           ledFlags;
   logic [GS_WORD_W-1:0] grayscaleWord;
   logic [DATA_W-1:0]    controlLatch;
   logic [SHIFT_MSB:0]   seen, p;
   int                   fails, samplesChecked, cycles;
   lds_shift_port lds_shift_port_inst (.clk(clk), .rst_n(rst_n), .shiftClk(shiftClk), .serialIn(serialIn),
      .latchStrobe(latchStrobe), .serialOut(serialOut), .ledFlags(ledFlags), .grayscaleWord(grayscaleWord),
      .grayscaleValid(grayscaleValid), .grayscaleReady(grayscaleReady), .controlLatch(controlLatch),
      .controlStrobe(controlStrobe));
   lds_host_model host_inst (.shiftClk(shiftClk), .serialIn(serialIn), .latchStrobe(latchStrobe),
      .serialOut(serialOut));
   always #25 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [SHIFT_MSB:0] exp, input logic [SHIFT_MSB:0] got);
      samplesChecked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic t_passthru();
      p = {{24{32'h9e3779b9}}, 1'h1};
      host_inst.shift_frame(p, seen);
      check("reset_out", '0, seen);
      host_inst.shift_frame('0, seen);
      check("passthru", p, seen);
      $display("passthru done");
   endtask
   task automatic t_control();
      p = {1'h1, {24{32'hc3a50f1e}}};
      host_inst.shift_frame(p, seen);
      host_inst.pulse_latch();
      check("control", SHIFT_LEN'(p[DATA_W-1:0]), SHIFT_LEN'(controlLatch));
      $display("control done");
   endtask
   // stalled drain of 16 words, then status read-back
   task automatic t_gray();
      logic [SHIFT_MSB:0] q;
      int                 w;
      q = '0;
      for (int i = 0; i < GS_WORDS; i++)
         q[i*GS_WORD_W +: GS_WORD_W] = 48'h5a0f3c9e7100 + 48'(i);
      // flags change on a clock edge, well before the latch falls
      @(posedge clk);
      ledFlags <= {48'hf00dc0de1234, 48'h0123456789ab};
      host_inst.shift_frame(q, seen);
      check("control_out", p, seen);
      host_inst.pulse_latch();
      repeat (20) @(posedge clk);
      w = 0;
      for (int i = 0; i < 80 && w < GS_WORDS; i++)
      begin
         @(posedge clk);
         if (grayscaleValid === 1'h1 && grayscaleReady === 1'h1)
         begin
            check("gs_word", SHIFT_LEN'(q[w*GS_WORD_W +: GS_WORD_W]), SHIFT_LEN'(grayscaleWord));
            w++;
         end
         grayscaleReady <= ~grayscaleReady;
      end
      check("gs_count", SHIFT_LEN'(GS_WORDS), SHIFT_LEN'(w));
      host_inst.shift_frame('0, seen);
      check("status", SHIFT_LEN'(ledFlags), SHIFT_LEN'(seen[765:670]));
      $display("gray done");
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      rst_n = 1'h0;
      grayscaleReady = 1'h0;
      ledFlags = '0;
      // link domain sees edges inside the 12 reset cycles
      fork
         host_inst.tick(4);
         repeat (12) @(posedge clk);
      join
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      t_passthru();
      t_control();
      t_gray();
      complete_run();
   end
endmodule
bind lds_shift_port lds_shift_port_props lds_shift_port_props_inst (
   .clk            (clk),
   .rst_n          (rst_n),
   .shiftClk       (shiftClk),
   .serialIn       (serialIn),
   .latchStrobe    (latchStrobe),
   .serialOut      (serialOut),
   .ledFlags       (ledFlags),
   .grayscaleWord  (grayscaleWord),
   .grayscaleValid (grayscaleValid),
   .grayscaleReady (grayscaleReady),
   .controlLatch   (controlLatch),
   .controlStrobe  (controlStrobe)
);
